/* File: design/adc_seq_pkg.sv */
/*
 * Shared constants and types for the converter sequencer: register byte
 * offsets, field positions, reset values, timing counts and carriers.
 * Assumes a 32-bit APB slave with one aligned word per register.
 */
package adc_seq_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_MODE = 8'h00;
	localparam logic [7:0] OFS_RES = 8'h04;
	localparam logic [7:0] OFS_IFLAG = 8'h08;
	localparam logic [7:0] OFS_IMASK = 8'h0C;
	localparam logic [7:0] OFS_PER = 8'h10;
	localparam logic [7:0] OFS_RESULT = 8'h14;
	localparam logic [7:0] OFS_CHAN = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1C;
	// field positions
	localparam int MODE_RUN_BIT = 7;
	localparam int MODE_SCAN_BIT = 6;
	localparam int MODE_DIV_HI = 4;
	localparam int MODE_DIV_LO = 3;
	localparam int MODE_TIM_BIT = 1;
	localparam int MODE_CMP_BIT = 0;
	localparam int RES_SEL_BIT = 0;
	localparam int IFLAG_CONV_BIT = 1;
	localparam int IMASK_CONV_BIT = 1;
	localparam int PER_GATE_BIT = 5;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_CHAN_LSB = 1;
	// writable bit masks and reset values
	localparam logic [7:0] MODE_WMASK = 8'hDB;
	localparam logic [7:0] RES_WMASK = 8'h01;
	localparam logic [7:0] PER_WMASK = 8'h20;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] RES_RST = 8'h00;
	localparam logic [7:0] PER_RST = 8'h00;
	localparam logic [7:0] IMASK_ONES = 8'hFD;
	localparam logic IMASK_RST = 1'b1;
	localparam logic IFLAG_RST = 1'b0;
	localparam int CHAN_W = 3;
	localparam logic [CHAN_W-1:0] CHAN_RST = 3'h0;
	// clock division codes
	localparam logic [1:0] DIV_BY8 = 2'h0;
	localparam logic [1:0] DIV_BY4 = 2'h1;
	localparam logic [1:0] DIV_BY2 = 2'h2;
	localparam logic [1:0] DIV_BY1 = 2'h3;
	// conversion timing in conversion clock periods
	localparam logic [4:0] TOTAL_LONG = 5'h17;
	localparam logic [4:0] SAMP_LONG = 5'h09;
	localparam logic [4:0] TOTAL_SHORT = 5'h11;
	localparam logic [4:0] SAMP_SHORT = 5'h03;
	// approximation register and result layout
	localparam int SAR_W = 10;
	localparam int SAR_MSB = 9;
	localparam logic [4:0] BITS_10 = 5'h0A;
	localparam logic [4:0] BITS_8 = 5'h08;
	localparam int RESULT_PAD = 6;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SAMPLE = 2'b01,
		ST_CONVERT = 2'b11
	} seq_state_t;

	typedef struct packed {
		logic [1:0] div;
		logic timing;
		logic res8;
		logic scan;
	} conv_cfg_t;

	typedef struct packed {
		logic comparator_en;
		logic sampling;
		logic [CHAN_W-1:0] channel;
		logic [SAR_W-1:0] dac_code;
	} analog_ctl_t;
endpackage

/* File: design/conv_clock_div.sv */
/*
 * Conversion clock divider: a one-cycle tick every 8, 4, 2 or 1 system
 * clocks. Assumes the caller pulses clear when a conversion leaves idle.
 */
module conv_clock_div
	import adc_seq_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic enable,
	input wire logic clear,
	input wire logic [1:0] div_code,
	output logic tick
);
	logic [2:0] cnt_r;
	logic [2:0] cnt_nxt;
	logic [2:0] limit;

	// terminal count per division code
	assign limit = (div_code == DIV_BY8) ? 3'h7 :
		(div_code == DIV_BY4) ? 3'h3 :
		(div_code == DIV_BY2) ? 3'h1 : 3'h0;
	// no tick without enable, so a gated supply stops the sequencer
	assign tick = enable & ~clear & (cnt_r == limit);
	assign cnt_nxt = (clear | ~enable | tick) ? 3'h0 : cnt_r + 3'h1;

	// phase counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= 3'h0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end
endmodule

/* File: design/adc_sequencer_control.sv */
/*
 * Sequencer for a software-started successive-approximation converter,
 * with its APB register file, clock divider, timing, result and request flag.
 * Assumes the comparator answer comp_above is synchronous to pclk and
 * settles within one conversion clock after dac_code changes.
 */
// The APB register port and the placing of the registers were decided locally.
module adc_sequencer_control
	import adc_seq_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic comp_above,
	output analog_ctl_t analog,
	output logic conv_end_irq
);
	logic [7:0] mode_r;
	logic [7:0] res_r;
	logic [7:0] per_r;
	logic flag_r;
	logic mask_r;
	logic [CHAN_W-1:0] chan_sel_r;
	logic [CHAN_W-1:0] act_chan_r;
	logic [CHAN_W-1:0] act_chan_nxt;
	logic [15:0] result_r;
	logic [31:0] prdata_r;
	logic [4:0] period_r;
	logic [SAR_W-1:0] sar_r;
	logic [SAR_W-1:0] sar_nxt;
	conv_cfg_t cfg_r;
	conv_cfg_t cfg_nxt;
	seq_state_t state_r;
	seq_state_t state_nxt;

	// bus decode
	logic setup;
	logic access;
	logic sel_mode;
	logic sel_res;
	logic sel_iflag;
	logic sel_imask;
	logic sel_per;
	logic sel_result;
	logic sel_chan;
	logic sel_status;
	logic addr_ok;
	logic wr_ok;
	logic [31:0] rd_word;
	assign setup = psel & ~penable;
	assign access = psel & penable;
	assign sel_mode = (paddr == OFS_MODE);
	assign sel_res = (paddr == OFS_RES);
	assign sel_iflag = (paddr == OFS_IFLAG);
	assign sel_imask = (paddr == OFS_IMASK);
	assign sel_per = (paddr == OFS_PER);
	assign sel_result = (paddr == OFS_RESULT);
	assign sel_chan = (paddr == OFS_CHAN);
	assign sel_status = (paddr == OFS_STATUS);
	assign addr_ok = sel_mode | sel_res | sel_iflag | sel_imask | sel_per | sel_result | sel_chan | sel_status;
	// zero wait states; prdata is captured during setup
	assign pready = 1'b1;
	assign pslverr = access & ~addr_ok;
	assign wr_ok = access & pwrite & addr_ok;
	assign prdata = prdata_r;

	// control fields
	logic run_bit;
	logic cmp_bit;
	logic gate_bit;
	logic may_run;
	logic busy;
	assign run_bit = mode_r[MODE_RUN_BIT];
	assign cmp_bit = mode_r[MODE_CMP_BIT];
	assign gate_bit = per_r[PER_GATE_BIT];
	assign may_run = run_bit & cmp_bit & gate_bit;
	assign busy = (state_r != ST_IDLE);

	// status word shows live sequencer state
	logic [31:0] status_word;
	assign status_word = {{(31-CHAN_W){1'b0}}, act_chan_r, busy};

	// read mux; unused upper bits read zero, mask spare bits read one
	assign rd_word = sel_mode ? {24'h000000, mode_r} :
		sel_res ? {24'h000000, res_r} :
		sel_iflag ? {30'h00000000, flag_r, 1'b0} :
		sel_imask ? {24'h000000, IMASK_ONES | {6'h00, mask_r, 1'b0}} :
		sel_per ? {24'h000000, per_r} :
		sel_result ? {16'h0000, result_r} :
		sel_chan ? {{(32-CHAN_W){1'b0}}, chan_sel_r} :
		sel_status ? status_word : 32'h00000000;

	// timing of the latched configuration
	logic conv_tick;
	logic restart;
	logic start;
	logic last_samp;
	logic conv_end;
	logic [4:0] total;
	logic [4:0] samp;
	logic [4:0] step;
	logic [4:0] nbits;
	logic sar_step;
	assign total = cfg_r.timing ? TOTAL_SHORT : TOTAL_LONG;
	assign samp = cfg_r.timing ? SAMP_SHORT : SAMP_LONG;
	assign nbits = cfg_r.res8 ? BITS_8 : BITS_10;
	assign step = period_r - samp;
	assign start = (state_r == ST_IDLE) & may_run;
	assign last_samp = (state_r == ST_SAMPLE) & may_run & conv_tick & (period_r == samp - 5'h01);
	assign conv_end = (state_r == ST_CONVERT) & may_run & conv_tick & (period_r == total - 5'h01);
	// sequential mode: the next conversion follows at once
	assign restart = start | (conv_end & may_run);
	assign sar_step = (state_r == ST_CONVERT) & conv_tick & (step < nbits);

	// clear only from idle: the end tick zeroes the count itself, and clearing there would loop via conv_end
	conv_clock_div u_div (
		.pclk(pclk),
		.presetn(presetn),
		.enable(busy & gate_bit),
		.clear(start),
		.div_code(cfg_r.div),
		.tick(conv_tick)
	);

	// configuration is frozen per conversion so mid-run writes are safe
	assign cfg_nxt = restart ? '{div: mode_r[MODE_DIV_HI:MODE_DIV_LO], timing: mode_r[MODE_TIM_BIT],
		res8: res_r[RES_SEL_BIT], scan: mode_r[MODE_SCAN_BIT]} : cfg_r;

	// sequencer next state
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (may_run) begin
					state_nxt = ST_SAMPLE;
				end
			end
			ST_SAMPLE: begin
				if (!may_run) begin
					state_nxt = ST_IDLE;
				end else if (last_samp) begin
					state_nxt = ST_CONVERT;
				end
			end
			ST_CONVERT: begin
				if (!may_run) begin
					state_nxt = ST_IDLE;
				end else if (conv_end) begin
					state_nxt = ST_SAMPLE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// approximation bits: trial bit kept on a high answer, next bit tried
	genvar gi;
	generate
		for (gi = 0; gi < SAR_W; gi++) begin : g_sar
			logic is_trial;
			logic is_next;
			assign is_trial = (step == 5'(SAR_MSB - gi));
			assign is_next = (step == 5'(SAR_MSB - 1 - gi)) & ((step + 5'h01) < nbits);
			assign sar_nxt[gi] = last_samp ? (gi == SAR_MSB) :
				restart ? 1'b0 :
				sar_step ? (is_trial ? (sar_r[gi] & comp_above) : (is_next | sar_r[gi])) :
				sar_r[gi];
		end
	endgenerate

	// scan walks 0 up to the selected channel, select holds it
	assign act_chan_nxt = !restart ? act_chan_r :
		!cfg_nxt.scan ? chan_sel_r :
		start ? CHAN_RST :
		(act_chan_r >= chan_sel_r) ? CHAN_RST : act_chan_r + 3'h1;

	// sequencer registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ST_IDLE;
			period_r <= 5'h00;
			sar_r <= '0;
			cfg_r <= '0;
			act_chan_r <= CHAN_RST;
		end else begin
			state_r <= state_nxt;
			period_r <= restart ? 5'h00 : (conv_tick ? period_r + 5'h01 : period_r);
			sar_r <= sar_nxt;
			cfg_r <= cfg_nxt;
			act_chan_r <= act_chan_nxt;
		end
	end

	// result word, left-aligned; taken from sar_r since sar_nxt is already cleared for the next run
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_r <= 16'h0000;
		end else if (conv_end) begin
			result_r <= {sar_r, {RESULT_PAD{1'b0}}};
		end
	end

	// request flag: a conversion end beats a software clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_r <= IFLAG_RST;
		end else if (conv_end) begin
			flag_r <= 1'b1;
		end else if (wr_ok & sel_iflag) begin
			flag_r <= pwdata[IFLAG_CONV_BIT];
		end
	end

	// software registers; only documented bits are stored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_r <= MODE_RST;
			res_r <= RES_RST;
			per_r <= PER_RST;
			mask_r <= IMASK_RST;
			chan_sel_r <= CHAN_RST;
		end else if (wr_ok) begin
			mode_r <= sel_mode ? (pwdata[7:0] & MODE_WMASK) : mode_r;
			res_r <= sel_res ? (pwdata[7:0] & RES_WMASK) : res_r;
			per_r <= sel_per ? (pwdata[7:0] & PER_WMASK) : per_r;
			mask_r <= sel_imask ? pwdata[IMASK_CONV_BIT] : mask_r;
			chan_sel_r <= sel_chan ? pwdata[CHAN_W-1:0] : chan_sel_r;
		end
	end

	// read data captured in setup so it is a flop in the access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h00000000;
		end else if (setup & ~pwrite) begin
			prdata_r <= rd_word;
		end
	end

	// outputs toward the analog side and the interrupt controller
	assign analog = '{comparator_en: cmp_bit, sampling: (state_r == ST_SAMPLE),
		channel: act_chan_r, dac_code: sar_r};
	assign conv_end_irq = flag_r & ~mask_r;

	// checking helpers: system clocks since conversion start
	logic [7:0] conv_cycle_r;
	logic [1:0] div_shift;
	logic [7:0] expect_len;
	logic [7:0] expect_samp;
	logic [7:0] div_mask;
	assign div_shift = 2'h3 - cfg_r.div;
	assign expect_len = {3'h0, total} << div_shift;
	assign expect_samp = {3'h0, samp} << div_shift;
	assign div_mask = (8'h01 << div_shift) - 8'h01;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conv_cycle_r <= 8'h00;
		end else begin
			conv_cycle_r <= restart ? 8'h01 : (busy ? conv_cycle_r + 8'h01 : 8'h00);
		end
	end

	a_tick_div_spacing: assert property (@(posedge pclk) disable iff (!presetn)
		(conv_tick && busy) |-> ((conv_cycle_r & div_mask) == 8'h00))
		else $error("conversion clock tick off its division grid");
	a_long_conv_len: assert property (@(posedge pclk) disable iff (!presetn)
		(conv_end && !cfg_r.timing) |-> (conv_cycle_r == expect_len) && (total == 5'h17))
		else $error("long timing conversion length wrong");
	a_long_samp_len: assert property (@(posedge pclk) disable iff (!presetn)
		(last_samp && !cfg_r.timing) |-> (conv_cycle_r == expect_samp) && (samp == 5'h09))
		else $error("long timing sampling length wrong");
	a_short_conv_len: assert property (@(posedge pclk) disable iff (!presetn)
		(conv_end && cfg_r.timing) |-> (conv_cycle_r == expect_len) && (expect_samp == ({3'h0, 5'h03} << div_shift)))
		else $error("short timing conversion length wrong");
	a_res8_low_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(conv_end && cfg_r.res8) |=> (result_r[RESULT_PAD+1:RESULT_PAD] == 2'h0))
		else $error("8-bit result has low bits set");
	a_flag_after_end: assert property (@(posedge pclk) disable iff (!presetn)
		conv_end |=> flag_r ##0 (result_r[15:RESULT_PAD] == $past(sar_r)))
		else $error("request flag not set at conversion end");
	a_irq_mask_gate: assert property (@(posedge pclk) disable iff (!presetn)
		(conv_end && !mask_r && !(wr_ok && sel_imask)) |=> conv_end_irq)
		else $error("unmasked conversion end gave no interrupt");
	a_comp_off_stop: assert property (@(posedge pclk) disable iff (!presetn)
		(!cmp_bit) |=> (state_r == ST_IDLE) || $rose(cmp_bit))
		else $error("sequencer ran with comparator stopped");
	a_run_clear_halt: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_ok && sel_mode && !pwdata[MODE_RUN_BIT]) |=> ##1 !busy ##1 !busy)
		else $error("clearing run did not halt conversion");
	a_select_chan_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(restart && !cfg_nxt.scan) |=> (act_chan_r == $past(chan_sel_r)))
		else $error("select mode changed the channel");
	a_gate_no_tick: assert property (@(posedge pclk) disable iff (!presetn)
		!gate_bit |-> !conv_tick && !conv_end)
		else $error("converter clocked while gated off");
	a_result_left_aligned: assert property (@(posedge pclk) disable iff (!presetn)
		$changed(result_r) |-> (result_r[RESULT_PAD-1:0] == 6'h00))
		else $error("result word not left-aligned");
	// short sampling, mask, flag clear, abort, trial bit, channel walk, gate and start
	a_short_samp_len: assert property (@(posedge pclk) disable iff (!presetn)
		(last_samp && cfg_r.timing) |-> (conv_cycle_r == expect_samp) && (samp == 5'h03))
		else $error("short timing sampling length wrong");
	a_irq_masked_low: assert property (@(posedge pclk) disable iff (!presetn)
		mask_r |-> !conv_end_irq)
		else $error("masked request reached the interrupt output");
	a_flag_clear_low: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_ok && sel_iflag && !pwdata[IFLAG_CONV_BIT] && !conv_end) |=> !flag_r)
		else $error("request flag not cleared by software");
	a_abort_no_result: assert property (@(posedge pclk) disable iff (!presetn)
		(busy && !may_run) |=> !busy && $stable(result_r))
		else $error("aborted conversion left a result or kept running");
	a_trial_bit_start: assert property (@(posedge pclk) disable iff (!presetn)
		last_samp |=> (sar_r == 10'h200))
		else $error("conversion phase did not start with the top trial bit");
	a_scan_chan_bound: assert property (@(posedge pclk) disable iff (!presetn)
		(restart && cfg_nxt.scan) |=> (act_chan_r <= $past(chan_sel_r)))
		else $error("scan went past the selected channel");
	a_gate_off_idle: assert property (@(posedge pclk) disable iff (!presetn)
		!gate_bit |=> !busy)
		else $error("sequencer busy with clock gate off");
	a_start_sampling: assert property (@(posedge pclk) disable iff (!presetn)
		start |=> analog.sampling)
		else $error("conversion start did not enter sampling");
endmodule

/* File: tb/adc_sequencer_control_bench.sv */
/*
 * Self-checking bench for the converter sequencer: APB register access,
 * conversion timing per division and timing code, result layout, request
 * flag and mask, aborts, clock gate and channel modes.
 * Assumes the design answers APB with zero wait states and that comp_above
 * may be held constant for a whole conversion.
 */
module adc_sequencer_control_bench
	import adc_seq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic comp_above = 1'b0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	analog_ctl_t analog;
	logic conv_end_irq;
	int bad_count = 0;
	int total_checks = 0;
	logic [31:0] rd;
	logic er;
	int s;
	int t;
	int dv;
	logic [2:0] ch;

	// 50 ns period
	initial begin
		forever #25 pclk = ~pclk;
	end

	adc_sequencer_control i_dut (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.comp_above(comp_above),
		.analog(analog),
		.conv_end_irq(conv_end_irq)
	);

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			bad_count++;
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, rd, er);
	endtask

	task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000, rd, er);
		check(name, rd, exp);
	endtask

	// cycles of sampling and from one conversion start to the next
	task automatic measure(output int samp, output int tot, output logic [2:0] c);
		int n;
		n = 0;
		@(posedge pclk);
		#1;
		while (analog.sampling !== 1'b1 && n < 400) begin
			@(posedge pclk);
			#1;
			n++;
		end
		c = analog.channel;
		samp = 0;
		while (analog.sampling === 1'b1 && samp < 400) begin
			@(posedge pclk);
			#1;
			samp++;
		end
		tot = samp;
		while (analog.sampling !== 1'b1 && tot < 400) begin
			@(posedge pclk);
			#1;
			tot++;
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// watchdog, well beyond the few thousand cycles the sequence needs
	initial begin
		repeat (40000) @(posedge pclk);
		bad_count++;
		report_and_stop();
	end

	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk("mode rst", OFS_MODE, 32'h0000_0000);
		rd_chk("res rst", OFS_RES, 32'h0000_0000);
		rd_chk("flag rst", OFS_IFLAG, 32'h0000_0000);
		rd_chk("mask rst", OFS_IMASK, 32'h0000_00FF);
		rd_chk("per rst", OFS_PER, 32'h0000_0000);
		check("irq rst", {31'h0, conv_end_irq}, 32'h0);
		// unmapped place is refused
		apb(1'b0, 8'h20, 32'h0000_0000, rd, er);
		check("unmapped err", {31'h0, er}, 32'h1);
		check("unmapped data", rd, 32'h0000_0000);
		// reserved bits are dropped, run stays off
		wr(OFS_MODE, 32'h0000_0066);
		rd_chk("mode reserved", OFS_MODE, 32'h0000_0042);
		wr(OFS_RES, 32'h0000_00FF);
		rd_chk("res reserved", OFS_RES, 32'h0000_0001);
		wr(OFS_RES, 32'h0000_0000);
		// gate still off: nothing may start
		wr(OFS_MODE, 32'h0000_0099);
		repeat (300) @(posedge pclk);
		rd_chk("gate off flag", OFS_IFLAG, 32'h0000_0000);
		rd_chk("gate off status", OFS_STATUS, 32'h0000_0000);
		check("cmp on", {31'h0, analog.comparator_en}, 32'h1);
		wr(OFS_PER, 32'h0000_0020);
		comp_above <= 1'b1;
		// every division and timing code, restarted from idle
		for (int code = 0; code < 4; code++) begin
			for (int tim = 0; tim < 2; tim++) begin
				dv = 8 >> code;
				wr(OFS_MODE, 32'h0000_0000);
				wr(OFS_MODE, 32'(32'h81 | (code << 3) | (tim << 1)));
				measure(s, t, ch);
				check("sample len", 32'(s), 32'((tim ? SAMP_SHORT : SAMP_LONG) * dv));
				check("conv len", 32'(t), 32'((tim ? TOTAL_SHORT : TOTAL_LONG) * dv));
			end
		end
		rd_chk("flag set", OFS_IFLAG, 32'h0000_0002);
		check("irq masked", {31'h0, conv_end_irq}, 32'h0);
		wr(OFS_IMASK, 32'h0000_0000);
		rd_chk("mask clear", OFS_IMASK, 32'h0000_00FD);
		check("irq open", {31'h0, conv_end_irq}, 32'h1);
		wr(OFS_IMASK, 32'h0000_0002);
		rd_chk("result 10", OFS_RESULT, 32'h0000_FFC0);
		// config is latched per conversion, so skip one before reading
		wr(OFS_RES, 32'h0000_0001);
		measure(s, t, ch);
		measure(s, t, ch);
		rd_chk("result 8", OFS_RESULT, 32'h0000_FF00);
		comp_above <= 1'b0;
		wr(OFS_RES, 32'h0000_0000);
		measure(s, t, ch);
		measure(s, t, ch);
		rd_chk("result low", OFS_RESULT, 32'h0000_0000);
		wr(OFS_MODE, 32'h0000_0000);
		wr(OFS_IFLAG, 32'h0000_0000);
		rd_chk("flag clear", OFS_IFLAG, 32'h0000_0000);
		// run cleared in mid conversion: no request, status idle
		wr(OFS_MODE, 32'h0000_0081);
		repeat (60) @(posedge pclk);
		wr(OFS_MODE, 32'h0000_0001);
		repeat (300) @(posedge pclk);
		rd_chk("abort flag", OFS_IFLAG, 32'h0000_0000);
		rd_chk("abort status", OFS_STATUS, 32'h0000_0000);
		// comparator stopped in mid conversion
		wr(OFS_MODE, 32'h0000_0099);
		repeat (5) @(posedge pclk);
		wr(OFS_MODE, 32'h0000_0098);
		@(posedge pclk);
		#1;
		check("cmp off", {31'h0, analog.comparator_en}, 32'h0);
		repeat (40) @(posedge pclk);
		rd_chk("cmp abort flag", OFS_IFLAG, 32'h0000_0000);
		// scan walks 0..select then wraps
		wr(OFS_MODE, 32'h0000_0000);
		wr(OFS_CHAN, 32'h0000_0002);
		wr(OFS_MODE, 32'h0000_00DB);
		for (int i = 0; i < 4; i++) begin
			measure(s, t, ch);
			check("scan chan", {29'h0, ch}, 32'(i % 3));
		end
		wr(OFS_MODE, 32'h0000_0000);
		wr(OFS_CHAN, 32'h0000_0005);
		wr(OFS_MODE, 32'h0000_009B);
		measure(s, t, ch);
		check("select chan", {29'h0, ch}, 32'h5);
		// top trial bit after three sampling clocks, then dropped on a low answer
		repeat (3) @(posedge pclk);
		#1;
		check("trial code", {22'h0, analog.dac_code}, 32'h0000_0200);
		@(posedge pclk);
		#1;
		check("first decision", {22'h0, analog.dac_code}, 32'h0000_0100);
		wr(OFS_MODE, 32'h0000_0000);
		report_and_stop();
	end
endmodule
